// >>> design/slor_pkg.sv
package slor_pkg;
  localparam int          NUM_LANES    = 4;
  localparam int          IRQ_W        = 2 * NUM_LANES;
  localparam logic [11:0] OFF_OUT_STAT = 12'h004;
  localparam logic [11:0] OFF_RX_TX_OVERRIDE_ENABLE  = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h400;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h404;
  localparam int          LANE_LSB     = 8;
  localparam int          TX_TX_OVERRIDE_ENABLE_BIT  = 31;
  localparam int          BOOST_LSB    = 22;
  localparam int          KEEP_TX_LSB  = 3;
  localparam int          LOSS_BIT     = 2;
  localparam int          RX_TX_OVERRIDE_ENABLE_BIT  = 14;
  localparam int          FILT_LSB     = 12;
  localparam int          EQ_LSB       = 5;
  localparam int          ALIGN_BIT    = 3;
  localparam int          HALF_BIT     = 0;
  localparam logic [31:0] TX_RST       = 32'h0000_0000;
  localparam logic [31:0] TX_WMASK     = 32'hFFFF_FFF8;
  localparam logic [31:0] RX_RST       = 32'h0000_101E;
  localparam logic [31:0] RX_WMASK     = 32'h0000_7FFF;
  localparam logic [7:0]  HEAVY_TICKS  = 8'h80;

  typedef enum logic [1:0] {
    FILT_OFF   = 2'b00,
    FILT_RSV_A = 2'b01,
    FILT_RSV_B = 2'b10,
    FILT_HEAVY = 2'b11
  } slor_filt_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_TX   = 3'h1,
    SEL_RX   = 3'h2,
    SEL_ISTA = 3'h3,
    SEL_IMSK = 3'h4
  } slor_sel_t;
endpackage

// >>> design/slor_lane_if.sv
`timescale 1ns/10ps
interface slor_lane_if;
  import slor_pkg::*;
  logic       tx_tx_override_enable_en;
  logic [3:0] boost_reg;
  logic       rx_tx_override_enable_en;
  slor_filt_t filt_reg;
  logic [2:0] eq_reg;
  logic       align_reg;
  logic       half_reg;
  logic [3:0] d_boost;
  slor_filt_t d_filt;
  logic [2:0] d_eq;
  logic       d_align;
  logic       d_half;
  logic [3:0] a_boost;
  slor_filt_t a_filt;
  logic [2:0] a_eq;
  logic       a_align;
  logic       a_half;

  modport regs (
    output tx_tx_override_enable_en, boost_reg, rx_tx_override_enable_en, filt_reg, eq_reg, align_reg, half_reg,
    output d_boost, d_filt, d_eq, d_align, d_half,
    input  a_boost, a_filt, a_eq, a_align, a_half
  );
  modport apply (
    input  tx_tx_override_enable_en, boost_reg, rx_tx_override_enable_en, filt_reg, eq_reg, align_reg, half_reg,
    input  d_boost, d_filt, d_eq, d_align, d_half,
    output a_boost, a_filt, a_eq, a_align, a_half
  );
endinterface

// >>> design/slor_lane_apply.sv
`timescale 1ns/10ps
module slor_lane_apply
  import slor_pkg::*;
(
  // Lane settings
  slor_lane_if.apply lif
);
  always_comb begin
    lif.a_boost = lif.tx_tx_override_enable_en ? lif.boost_reg : lif.d_boost;
  end

  always_comb begin
    if (lif.rx_tx_override_enable_en) begin
      lif.a_filt  = lif.filt_reg;
      lif.a_eq    = lif.eq_reg;
      lif.a_align = lif.align_reg;
      lif.a_half  = lif.half_reg;
    end else begin
      lif.a_filt  = lif.d_filt;
      lif.a_eq    = lif.d_eq;
      lif.a_align = lif.d_align;
      lif.a_half  = lif.d_half;
    end
  end
endmodule

// >>> design/slor_los_filter.sv
`timescale 1ns/10ps
module slor_los_filter
  import slor_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Lane side
  input  wire logic presc_tick,
  input  wire logic no_signal,
  input  slor_filt_t filt_sel,
  output logic       signal_loss
);
  typedef struct packed {
    logic [7:0] ticks;
    logic       loss;
  } slor_flt_t;

  slor_flt_t s;
  slor_flt_t next_s;

  // The flag only moves on a prescaler tick, so it stays in step with it.
  always_comb begin
    next_s = s;
    if (presc_tick) begin
      if (!no_signal) begin
        next_s.ticks = 8'h00;
        next_s.loss  = 1'b0;
      end else if (filt_sel == FILT_HEAVY) begin
        if (s.ticks != HEAVY_TICKS) begin
          next_s.ticks = s.ticks + 8'h01;
        end
        next_s.loss = (s.ticks >= HEAVY_TICKS - 8'h01);
      end else begin
        next_s.ticks = 8'h00;
        next_s.loss  = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign signal_loss = s.loss;
endmodule

// >>> design/slor_regs.sv
// Behaviour
// - Bit 31 selects register transmit fields over power-up defaults; resets clear.
// - Transmit boost field bits 25:22, reset zero, drives lane boost.
// - Loss-of-signal flag readable at bit 2, read only.
// - Bit 14 selects receive fields 13:0 over power-up defaults; resets clear.
// - Filter field 13:12: 00 off, 11 heavy, others reserved.
// - Heavy filter flags loss after 128 silent prescaler ticks.
// - Equalizer field bits 7:5, reset 000, drives lane equalizer level.
// - Bit 3 enables word alignment framer; resets to one.
// - Bit 0 drives half-rate control when receive override is on.
// - Default status fields flagged invalid while an override is active.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module slor_regs
  import slor_pkg::*;
(
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Lane inputs
  input  wire logic                            presc_tick,
  input  wire logic [NUM_LANES-1:0]            lane_no_signal,
  input  wire logic [NUM_LANES-1:0][3:0]       dflt_tx_boost,
  input  wire logic [NUM_LANES-1:0][1:0]       dflt_filter_sel,
  input  wire logic [NUM_LANES-1:0][2:0]       dflt_rx_eq,
  input  wire logic [NUM_LANES-1:0]            dflt_align_en,
  input  wire logic [NUM_LANES-1:0]            dflt_half_rate,
  // Lane outputs
  output logic      [NUM_LANES-1:0][3:0]       lane_tx_boost,
  output logic      [NUM_LANES-1:0][1:0]       signal_loss_filter_sel,
  output logic      [NUM_LANES-1:0][2:0]       rx_equalizer_level,
  output logic      [NUM_LANES-1:0]            lane_align_en,
  output logic      [NUM_LANES-1:0]            lane_half_rate,
  output logic      [NUM_LANES-1:0]            signal_loss_flag,
  output logic      [NUM_LANES-1:0]            dflt_tx_valid,
  output logic      [NUM_LANES-1:0]            dflt_rx_valid,
  // Interrupt
  output logic                                 irq
);
  typedef struct packed {
    logic [NUM_LANES-1:0][31:0] tx;
    logic [NUM_LANES-1:0][31:0] rx;
    logic [31:0]                rdata;
    logic [IRQ_W-1:0]           irq_stat;
    logic [IRQ_W-1:0]           irq_mask;
    logic [NUM_LANES-1:0]       loss_q;
    logic [NUM_LANES-1:0][3:0]  boost;
    logic [NUM_LANES-1:0][1:0]  filt;
    logic [NUM_LANES-1:0][2:0]  eq;
    logic [NUM_LANES-1:0]       align;
    logic [NUM_LANES-1:0]       half;
    logic [NUM_LANES-1:0]       tx_ok;
    logic [NUM_LANES-1:0]       rx_ok;
  } slor_main_t;

  slor_main_t s;
  slor_main_t next_s;

  logic [NUM_LANES-1:0]      flt_loss;
  logic [NUM_LANES-1:0][3:0] a_boost;
  logic [NUM_LANES-1:0][1:0] a_filt;
  logic [NUM_LANES-1:0][2:0] a_eq;
  logic [NUM_LANES-1:0]      a_align;
  logic [NUM_LANES-1:0]      a_half;

  // Address decode, shared by the read and write phases.
  function automatic slor_sel_t decode(input logic [11:0] a);
    logic [11:0] off;
    off = {4'h0, a[7:0]};
    if (a == OFF_IRQ_STAT) begin
      decode = SEL_ISTA;
    end else if (a == OFF_IRQ_MASK) begin
      decode = SEL_IMSK;
    end else if (a[11:10] != 2'b00) begin
      decode = SEL_NONE;
    end else if (off == OFF_OUT_STAT) begin
      decode = SEL_TX;
    end else if (off == OFF_RX_TX_OVERRIDE_ENABLE) begin
      decode = SEL_RX;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  slor_lane_if lif[NUM_LANES] ();

  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    assign lif[g].tx_tx_override_enable_en = s.tx[g][TX_TX_OVERRIDE_ENABLE_BIT];
    assign lif[g].boost_reg  = s.tx[g][BOOST_LSB +: 4];
    assign lif[g].rx_tx_override_enable_en = s.rx[g][RX_TX_OVERRIDE_ENABLE_BIT];
    assign lif[g].filt_reg   = slor_filt_t'(s.rx[g][FILT_LSB +: 2]);
    assign lif[g].eq_reg     = s.rx[g][EQ_LSB +: 3];
    assign lif[g].align_reg  = s.rx[g][ALIGN_BIT];
    assign lif[g].half_reg   = s.rx[g][HALF_BIT];
    assign lif[g].d_boost    = dflt_tx_boost[g];
    assign lif[g].d_filt     = slor_filt_t'(dflt_filter_sel[g]);
    assign lif[g].d_eq       = dflt_rx_eq[g];
    assign lif[g].d_align    = dflt_align_en[g];
    assign lif[g].d_half     = dflt_half_rate[g];
    assign a_boost[g]        = lif[g].a_boost;
    assign a_filt[g]         = lif[g].a_filt;
    assign a_eq[g]           = lif[g].a_eq;
    assign a_align[g]        = lif[g].a_align;
    assign a_half[g]         = lif[g].a_half;

    slor_lane_apply i_slor_lane_apply (
      .lif (lif[g])
    );

    slor_los_filter i_slor_los_filter (
      .core_clk    (core_clk),
      .rst         (rst),
      .presc_tick  (presc_tick),
      .no_signal   (lane_no_signal[g]),
      .filt_sel    (lif[g].a_filt),
      .signal_loss (flt_loss[g])
    );
  end

  always_comb begin
    logic       setup;
    logic       wr;
    logic [1:0] lane;
    slor_sel_t  sel;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] set;
    next_s = s;
    setup  = psel && !penable;
    wr     = psel && penable && pwrite;
    lane   = paddr[LANE_LSB +: 2];
    sel    = decode(paddr);
    clr    = '0;
    // Events: loss asserted in the low half, loss cleared in the high half.
    set    = {s.loss_q & ~flt_loss, flt_loss & ~s.loss_q};

    // Read data is loaded in the setup phase and shown in the access phase.
    if (setup) begin
      unique case (sel)
        SEL_TX: begin
          next_s.rdata = {s.tx[lane][31:KEEP_TX_LSB], s.loss_q[lane], 2'b00};
        end
        SEL_RX: begin
          next_s.rdata = s.rx[lane] & RX_WMASK;
        end
        SEL_ISTA: begin
          next_s.rdata = {{(32 - IRQ_W){1'b0}}, s.irq_stat};
        end
        SEL_IMSK: begin
          next_s.rdata = {{(32 - IRQ_W){1'b0}}, s.irq_mask};
        end
        SEL_NONE: begin
          next_s.rdata = 32'h0000_0000;
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (wr) begin
      unique case (sel)
        SEL_TX: begin
          next_s.tx[lane] = pwdata & TX_WMASK;
        end
        SEL_RX: begin
          next_s.rx[lane] = pwdata & RX_WMASK;
        end
        SEL_ISTA: begin
          clr = pwdata[IRQ_W-1:0];
        end
        SEL_IMSK: begin
          next_s.irq_mask = pwdata[IRQ_W-1:0];
        end
        SEL_NONE: begin
          next_s.irq_mask = s.irq_mask;
        end
        default: begin
          next_s.irq_mask = s.irq_mask;
        end
      endcase
    end

    // A new event beats a clear in the same cycle.
    next_s.irq_stat = (s.irq_stat & ~clr) | set;
    next_s.loss_q   = flt_loss;

    next_s.boost = a_boost;
    next_s.filt  = a_filt;
    next_s.eq    = a_eq;
    next_s.align = a_align;
    next_s.half  = a_half;
    for (int i = 0; i < NUM_LANES; i++) begin
      next_s.tx_ok[i] = !next_s.tx[i][TX_TX_OVERRIDE_ENABLE_BIT];
      next_s.rx_ok[i] = !next_s.rx[i][RX_TX_OVERRIDE_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_LANES; i++) begin
        s.tx[i] <= TX_RST;
        s.rx[i] <= RX_RST;
      end
      s.rdata    <= 32'h0000_0000;
      s.irq_stat <= '0;
      s.irq_mask <= '0;
      s.loss_q   <= '0;
      s.boost    <= '0;
      s.filt     <= '0;
      s.eq       <= '0;
      s.align    <= '0;
      s.half     <= '0;
      s.tx_ok    <= '1;
      s.rx_ok    <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.rdata;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && (decode(paddr) == SEL_NONE);
  assign irq     = |(s.irq_stat & s.irq_mask);

  assign lane_tx_boost          = s.boost;
  assign signal_loss_filter_sel = s.filt;
  assign rx_equalizer_level     = s.eq;
  assign lane_align_en          = s.align;
  assign lane_half_rate         = s.half;
  assign signal_loss_flag       = s.loss_q;
  assign dflt_tx_valid          = s.tx_ok;
  assign dflt_rx_valid          = s.rx_ok;
endmodule

// >>> verification/slor_checker.sv
`timescale 1ns/10ps
module slor_checker
  import slor_pkg::*;
(
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  // APB slave
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Lane
  input wire logic                      presc_tick,
  input wire logic [NUM_LANES-1:0][3:0] dflt_tx_boost,
  input wire logic [NUM_LANES-1:0][2:0] dflt_rx_eq,
  input wire logic [NUM_LANES-1:0]      dflt_align_en,
  input wire logic [NUM_LANES-1:0][3:0] lane_tx_boost,
  input wire logic [NUM_LANES-1:0][2:0] rx_equalizer_level,
  input wire logic [NUM_LANES-1:0]      lane_align_en,
  input wire logic [NUM_LANES-1:0]      signal_loss_flag,
  input wire logic [NUM_LANES-1:0]      dflt_tx_valid,
  input wire logic [NUM_LANES-1:0]      dflt_rx_valid
);
  logic acc;
  logic mapped;
  assign acc    = psel && penable;
  assign mapped = (paddr[11:10] == 2'b00 && (paddr[7:0] == 8'h04 || paddr[7:0] == 8'h08))
                  || paddr == 12'h400 || paddr == 12'h404;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_zero_wait: assert property (psel |-> pready == penable)
    else $error("pready does not match the access phase");
  a_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong for the address");
  a_unmapped_rdata: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_tx_read_bits: assert property (acc && !pwrite && paddr == 12'h004 |->
    prdata[1:0] == 2'b00 && prdata[31] == !dflt_tx_valid[0])
    else $error("transmit register readback wrong");
  a_rx_read_bits: assert property (acc && !pwrite && paddr == 12'h008 |->
    prdata[31:15] == 17'h0_0000 && prdata[14] == !dflt_rx_valid[0])
    else $error("receive register readback wrong");
  a_tx_dflt_sel: assert property (!$past(rst) && $past(dflt_tx_valid[0]) |->
    lane_tx_boost[0] == $past(dflt_tx_boost[0]))
    else $error("transmit default not applied");
  a_rx_dflt_sel: assert property (!$past(rst) && $past(dflt_rx_valid[0]) |->
    rx_equalizer_level[0] == $past(dflt_rx_eq[0]) && lane_align_en[0] == $past(dflt_align_en[0]))
    else $error("receive default not applied");
  a_loss_on_tick: assert property ($changed(signal_loss_flag) |->
    $past(presc_tick) || $past(presc_tick, 2) || $past(presc_tick, 3))
    else $error("loss flag moved without a prescaler tick");
endmodule

bind slor_regs slor_checker i_slor_checker (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .presc_tick,
  .dflt_tx_boost, .dflt_rx_eq, .dflt_align_en, .lane_tx_boost, .rx_equalizer_level,
  .lane_align_en, .signal_loss_flag, .dflt_tx_valid, .dflt_rx_valid
);

// >>> verification/serdes_lane_override_regs_tb.sv
`timescale 1ns/10ps
module serdes_lane_override_regs_tb;
  import slor_pkg::*;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic presc_tick = 1'b0, pready, pslverr, irq;
  logic [11:0]                paddr              = 12'h000;
  logic [31:0]                pwdata             = ZERO;
  logic [31:0]                prdata;
  logic [NUM_LANES-1:0]       lane_no_signal     = 4'h0;
  logic [NUM_LANES-1:0][3:0]  dflt_tx_boost      = 16'h4321;
  logic [NUM_LANES-1:0][1:0]  dflt_filter_sel    = 8'hFF;
  logic [NUM_LANES-1:0][2:0]  dflt_rx_eq         = 12'h8D1;
  logic [NUM_LANES-1:0]       dflt_align_en      = 4'hF;
  logic [NUM_LANES-1:0]       dflt_half_rate     = 4'h0;
  logic [NUM_LANES-1:0][3:0]  lane_tx_boost;
  logic [NUM_LANES-1:0][1:0]  signal_loss_filter_sel;
  logic [NUM_LANES-1:0][2:0]  rx_equalizer_level;
  logic [NUM_LANES-1:0]       lane_align_en, lane_half_rate, signal_loss_flag;
  logic [NUM_LANES-1:0]       dflt_tx_valid, dflt_rx_valid;
  int                         bad_count = 0;
  int                         checks_done = 0;

  always #20 core_clk = ~core_clk;

  slor_regs i_slor_regs (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .presc_tick, .lane_no_signal, .dflt_tx_boost, .dflt_filter_sel,
    .dflt_rx_eq, .dflt_align_en, .dflt_half_rate, .lane_tx_boost, .signal_loss_filter_sel,
    .rx_equalizer_level, .lane_align_en, .lane_half_rate, .signal_loss_flag, .dflt_tx_valid,
    .dflt_rx_valid, .irq);

  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; read data is compared only for reads.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic ee);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!w) chk("prdata", prdata, exp);
    chk("pslverr", 32'(pslverr), 32'(ee));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      presc_tick <= 1'b1;
      @(posedge core_clk);
      presc_tick <= 1'b0;
    end
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int n = 0; n < NUM_LANES; n++) begin
      xfer(1'b0, 12'(n * 256) + OFF_OUT_STAT, ZERO, ZERO, 1'b0);
      xfer(1'b0, 12'(n * 256) + OFF_RX_TX_OVERRIDE_ENABLE, ZERO, 32'h0000_101E, 1'b0);
    end
    xfer(1'b1, 12'h00C, 32'hFFFF_FFFF, ZERO, 1'b1);
    xfer(1'b0, 12'h00C, ZERO, ZERO, 1'b1);
    // Keep bits go back as last written; bits 2:0 are read only and must not store.
    xfer(1'b1, 12'h104, 32'hFFC0_0007, ZERO, 1'b0);
    xfer(1'b0, 12'h104, ZERO, 32'hFFC0_0000, 1'b0);
    xfer(1'b0, 12'h004, ZERO, ZERO, 1'b0);
    wt(2);
    chk("lane_tx_boost", 32'(lane_tx_boost), 32'h0000_43F1);
    chk("dflt_tx_valid", 32'(dflt_tx_valid), 32'h0000_000D);
    xfer(1'b1, 12'h104, 32'h01C0_0000, ZERO, 1'b0);
    wt(2);
    chk("lane_tx_boost", 32'(lane_tx_boost), 32'h0000_4321);
    xfer(1'b1, 12'h208, 32'h0000_40B7, ZERO, 1'b0);
    xfer(1'b0, 12'h208, ZERO, 32'h0000_40B7, 1'b0);
    xfer(1'b1, 12'h308, 32'h0000_701E, ZERO, 1'b0);
    wt(2);
    chk("rx_equalizer_level", 32'(rx_equalizer_level[2]), 32'h0000_0005);
    chk("lane_align_en", 32'(lane_align_en), 32'h0000_000B);
    chk("lane_half_rate", 32'(lane_half_rate), 32'h0000_0004);
    chk("filter_sel", 32'(signal_loss_filter_sel), 32'h0000_00CF);
    chk("dflt_rx_valid", 32'(dflt_rx_valid), 32'h0000_0003);
    @(posedge core_clk);
    lane_no_signal <= 4'h4;
    tick(1);
    wt(4);
    chk("signal_loss_flag", 32'(signal_loss_flag), 32'h0000_0004);
    xfer(1'b0, 12'h204, ZERO, 32'h0000_0004, 1'b0);
    xfer(1'b0, OFF_IRQ_STAT, ZERO, 32'h0000_0004, 1'b0);
    chk("irq", 32'(irq), ZERO);
    xfer(1'b1, OFF_IRQ_MASK, 32'h0000_0044, ZERO, 1'b0);
    wt(1);
    chk("irq", 32'(irq), 32'h0000_0001);
    xfer(1'b1, OFF_IRQ_STAT, 32'h0000_0004, ZERO, 1'b0);
    wt(1);
    chk("irq", 32'(irq), ZERO);
    @(posedge core_clk);
    lane_no_signal <= 4'h8;
    tick(122);
    wt(4);
    chk("signal_loss_flag", 32'(signal_loss_flag), ZERO);
    chk("irq", 32'(irq), 32'h0000_0001);
    xfer(1'b0, OFF_IRQ_STAT, ZERO, 32'h0000_0040, 1'b0);
    xfer(1'b1, OFF_IRQ_STAT, 32'h0000_0040, ZERO, 1'b0);
    tick(11);
    wt(4);
    chk("signal_loss_flag", 32'(signal_loss_flag), 32'h0000_0008);
    chk("irq", 32'(irq), ZERO);
    xfer(1'b0, OFF_IRQ_STAT, ZERO, 32'h0000_0008, 1'b0);
    report_and_stop;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    report_and_stop;
  end
endmodule
